// >>> hdl/dea_access_ctrl.sv
// Register front end of the data EEPROM
`timescale 1ns/1ps
`include "dea_defs.svh"
module dea_access_ctrl #(
  parameter int ADDR_BITS = `DEA_NV_ADDR_BITS,
  parameter int WRITE_CYCLES = `DEA_WRITE_CYCLES,
  parameter int unsigned POWERUP_CYCLES = `DEA_POWERUP_DELAY_TIMER_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input dea_pkg::dea_bus_req_type bus_req,
  output logic [7:0] reg_rdata,
  input wire logic external_reset_pin,
  input wire logic watchdog_timeout,
  output logic write_complete_flag,
  output logic write_busy,
  output logic powerup_delay_timer
);
  import dea_pkg::*;

  if (ADDR_BITS < 1 || ADDR_BITS > 8 || POWERUP_CYCLES < 1) begin : g_check
    $error("dea_access_ctrl: unsupported parameters");
  end

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic in_range(input logic [7:0] a);
    logic [7:0] hi;
    hi = a >> ADDR_BITS;
    in_range = (hi == 8'h00);
  endfunction : in_range

  function automatic logic hit(input dea_bus_req_type r, input logic [7:0] ofs);
    hit = r.wr_en && (r.addr == ofs);
  endfunction : hit

  dea_ctrl_type ctrl;
  dea_ctrl_type next_ctrl;
  dea_key_state_type key_state;
  dea_key_state_type next_key_state;
  logic [7:0] nv_data_value;
  logic [7:0] next_nv_data_value;
  logic [7:0] nv_byte_address;
  logic [7:0] next_nv_byte_address;
  logic [7:0] next_rdata;
  logic [31:0] powerup_delay_timer_count;
  logic [31:0] next_powerup_delay_timer_count;
  logic other_rst;
  logic ctrl_wr;
  logic start;
  logic done;
  logic busy;
  logic [7:0] arr_rdata;
  logic [7:0] rd_byte;

  assign other_rst = external_reset_pin || watchdog_timeout;
  assign ctrl_wr = hit(bus_req, `DEA_OFS_CTRL) && !other_rst;
  assign powerup_delay_timer = (powerup_delay_timer_count < 32'(POWERUP_CYCLES));
  assign write_complete_flag = ctrl.done;
  assign write_busy = busy;
  // Code protection has no path here: CPU access stays plain
  assign rd_byte = in_range(nv_byte_address) ? arr_rdata : 8'h00;

  // ----------------------------------------
  // Array and write timer
  // ----------------------------------------
  dea_nv_array #(
    .ADDR_BITS(ADDR_BITS),
    .WRITE_CYCLES(WRITE_CYCLES)
  ) dea_nv_array_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(start),
    .store(in_range(nv_byte_address)),
    .abort(other_rst),
    .wr_addr(nv_byte_address[ADDR_BITS-1:0]),
    .wr_data(nv_data_value),
    .rd_addr(nv_byte_address[ADDR_BITS-1:0]),
    .rd_data(arr_rdata),
    .busy(busy),
    .done(done)
  );

  // ----------------------------------------
  // Unlock sequence and write start
  // ----------------------------------------
  always_comb begin
    next_key_state = key_state;
    if (other_rst) begin
      next_key_state = DEA_KEY_IDLE;
    end else if (hit(bus_req, `DEA_OFS_KEY)) begin
      if (bus_req.wdata == `DEA_KEY_FIRST) begin
        next_key_state = DEA_KEY_GOT_FIRST;
      end else if (key_state == DEA_KEY_GOT_FIRST && bus_req.wdata == `DEA_KEY_SECOND) begin
        next_key_state = DEA_KEY_ARMED;
      end else begin
        next_key_state = DEA_KEY_IDLE;
      end
    end else if (bus_req.wr_en || bus_req.rd_en) begin
      next_key_state = DEA_KEY_IDLE;
    end
  end

  always_comb begin
    start = 1'b0;
    case (key_state)
      DEA_KEY_ARMED: begin
        start = ctrl_wr && bus_req.wdata[`DEA_BIT_WR] && ctrl.gate
          && !powerup_delay_timer && !busy;
      end
      default: begin
        start = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key_state <= DEA_KEY_IDLE;
    end else begin
      key_state <= next_key_state;
    end
  end

  // ----------------------------------------
  // Power-up delay
  // ----------------------------------------
  always_comb begin
    next_powerup_delay_timer_count = powerup_delay_timer_count;
    if (powerup_delay_timer) begin
      next_powerup_delay_timer_count = powerup_delay_timer_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      powerup_delay_timer_count <= 32'h0000_0000;
    end else begin
      powerup_delay_timer_count <= next_powerup_delay_timer_count;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_ctrl.rd = 1'b0;
    if (other_rst) begin
      next_ctrl.done = 1'b0;
      next_ctrl.abort = ctrl.abort || busy;
      next_ctrl.gate = 1'b0;
      next_ctrl.wr = 1'b0;
    end else begin
      if (ctrl_wr) begin
        next_ctrl.done = bus_req.wdata[`DEA_BIT_DONE];
        next_ctrl.abort = bus_req.wdata[`DEA_BIT_ABORT];
        next_ctrl.gate = bus_req.wdata[`DEA_BIT_GATE];
      end
      if (start) begin
        next_ctrl.wr = 1'b1;
      end
      if (done) begin
        next_ctrl.wr = 1'b0;
        next_ctrl.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------
  // Data and address registers, read port
  // ----------------------------------------
  always_comb begin
    next_nv_data_value = nv_data_value;
    next_nv_byte_address = nv_byte_address;
    next_rdata = reg_rdata;
    if (!other_rst) begin
      if (hit(bus_req, `DEA_OFS_DATA)) begin
        next_nv_data_value = bus_req.wdata;
      end
      if (hit(bus_req, `DEA_OFS_ADDR)) begin
        next_nv_byte_address = bus_req.wdata;
      end
      if (ctrl_wr && bus_req.wdata[`DEA_BIT_RD]) begin
        next_nv_data_value = rd_byte;
      end
      if (bus_req.rd_en) begin
        case (bus_req.addr)
          `DEA_OFS_DATA: next_rdata = nv_data_value;
          `DEA_OFS_ADDR: next_rdata = nv_byte_address;
          `DEA_OFS_CTRL: next_rdata = {3'b000, ctrl};
          default: next_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nv_data_value <= `DEA_BYTE_RESET;
      nv_byte_address <= `DEA_BYTE_RESET;
      reg_rdata <= `DEA_BYTE_RESET;
    end else begin
      nv_data_value <= next_nv_data_value;
      nv_byte_address <= next_nv_byte_address;
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_read_loads: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ctrl_wr && bus_req.wdata[`DEA_BIT_RD]) |=> (nv_data_value == $past(rd_byte)))
    else $error("read did not load data register");

  a_data_holds: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !(bus_req.wr_en && (bus_req.addr == `DEA_OFS_DATA || bus_req.addr == `DEA_OFS_CTRL))
    |=> $stable(nv_data_value))
    else $error("data register changed without cause");

  a_start_seq: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(busy) |-> ($past(key_state) == DEA_KEY_ARMED) && $past(ctrl_wr))
    else $error("write started without unlock");

  a_gate_needed: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(ctrl.wr) |-> $past(ctrl.gate))
    else $error("write started with gate clear");

  a_gate_sw_only: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(ctrl.gate) |-> $past(ctrl_wr) || $past(other_rst))
    else $error("gate cleared by hardware");

  a_wr_survives: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (busy && !done && !other_rst) |=> ctrl.wr && busy)
    else $error("write cycle disturbed");

  a_done_flags: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (done && !other_rst) |=> ctrl.done && !ctrl.wr)
    else $error("completion not reported");

  a_flag_sticky: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ctrl.done && !other_rst && !(ctrl_wr && !bus_req.wdata[`DEA_BIT_DONE])) |=> ctrl.done)
    else $error("complete flag lost");

  a_powerup_delay_timer_blocks: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    powerup_delay_timer |=> !$rose(busy))
    else $error("write during power-up delay");

  a_upper_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (bus_req.rd_en && bus_req.addr == `DEA_OFS_CTRL && !other_rst) |=> reg_rdata[7:5] == 3'b000)
    else $error("unused control bits not zero");

  a_trig_sticky: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ctrl.wr && !done && !other_rst) |=> ctrl.wr)
    else $error("write trigger cleared early");

  a_abort_flag: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (busy && other_rst) |=> ctrl.abort && !busy && $stable(nv_byte_address))
    else $error("abort not flagged");

  a_key_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (bus_req.rd_en && bus_req.addr == `DEA_OFS_KEY && !other_rst) |=> reg_rdata == 8'h00)
    else $error("unlock register read not zero");

  a_seq_broken: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (bus_req.rd_en && !bus_req.wr_en) |=> key_state == DEA_KEY_IDLE)
    else $error("unlock survived other access");

endmodule : dea_access_ctrl

// >>> hdl/dea_defs.svh
// Constants for the data EEPROM access controller
// What this block does
// - Addressed byte lands in data register next cycle
// - Data register holds until read or write
// - Write starts only after 55h, AAh, trigger
// - Write trigger refused while write gate clear
// - Only software writes and resets (power-up, reset pin, watchdog) clear the write gate
// - Clearing gate does not stop running write
// - Write end clears trigger, sets complete flag
// - Complete flag sticky until software, reset pin, watchdog or power-up clears it
// - Power-up clears the write gate
// - Power-up delay blocks any write start
// - Code protection leaves CPU access unchanged
// - Control resets 0x000 / 0q000, data kept
// - Only five control bits, upper three zero
// - Triggers set by software, cleared by hardware
// - Reset pin or watchdog during write sets abort, keeps registers
// - Unlock register has no storage, reads zero
`ifndef DEA_DEFS_SVH
`define DEA_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DEA_OFS_DATA 8'h08
`define DEA_OFS_ADDR 8'h09
`define DEA_OFS_CTRL 8'h88
`define DEA_OFS_KEY 8'h89

// ----------------------------------------
// Control field positions and values
// ----------------------------------------
`define DEA_BIT_RD 0
`define DEA_BIT_WR 1
`define DEA_BIT_GATE 2
`define DEA_BIT_ABORT 3
`define DEA_BIT_DONE 4
`define DEA_KEY_FIRST 8'h55
`define DEA_KEY_SECOND 8'haa
`define DEA_BYTE_RESET 8'h00

// ----------------------------------------
// Geometry and timing
// ----------------------------------------
`define DEA_NV_ADDR_BITS 6
`define DEA_CLK_KHZ 50000
`define DEA_POWERUP_DELAY_TIMER_MS 72
`define DEA_POWERUP_DELAY_TIMER_CYCLES (`DEA_POWERUP_DELAY_TIMER_MS * `DEA_CLK_KHZ)
`define DEA_WRITE_CYCLES 200

`endif

// >>> hdl/dea_pkg.sv
// Types shared by the data EEPROM access controller
package dea_pkg;

  typedef struct packed {
    logic done;
    logic abort;
    logic gate;
    logic wr;
    logic rd;
  } dea_ctrl_type;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dea_bus_req_type;

  typedef enum logic [1:0] {
    DEA_KEY_IDLE,
    DEA_KEY_GOT_FIRST,
    DEA_KEY_ARMED
  } dea_key_state_type;

endpackage : dea_pkg

// >>> hdl/dea_nv_array.sv
// Byte array with self-timed write cycle
`timescale 1ns/1ps
`include "dea_defs.svh"
module dea_nv_array #(
  parameter int ADDR_BITS = `DEA_NV_ADDR_BITS,
  parameter int WRITE_CYCLES = `DEA_WRITE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic store,
  input wire logic abort,
  input wire logic [ADDR_BITS-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [ADDR_BITS-1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic busy,
  output logic done
);
  import dea_pkg::*;

  localparam int DEPTH = 2 ** ADDR_BITS;

  if (ADDR_BITS < 1 || ADDR_BITS > 8 || WRITE_CYCLES < 1) begin : g_check
    $error("dea_nv_array: unsupported parameters");
  end

  logic [7:0] mem [DEPTH];
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_busy;
  logic keep;
  logic next_keep;
  logic [ADDR_BITS-1:0] lat_addr;
  logic [ADDR_BITS-1:0] next_lat_addr;
  logic [7:0] lat_data;
  logic [7:0] next_lat_data;

  // ----------------------------------------
  // Write timer
  // ----------------------------------------
  always_comb begin
    next_busy = busy;
    next_count = count;
    next_keep = keep;
    next_lat_addr = lat_addr;
    next_lat_data = lat_data;
    done = busy && !abort && (count == 32'(WRITE_CYCLES - 1));
    if (abort) begin
      next_busy = 1'b0;
      next_count = 32'h0000_0000;
    end else if (busy) begin
      if (done) begin
        next_busy = 1'b0;
        next_count = 32'h0000_0000;
      end else begin
        next_count = count + 32'h0000_0001;
      end
    end else if (start) begin
      next_busy = 1'b1;
      next_count = 32'h0000_0000;
      next_keep = store;
      next_lat_addr = wr_addr;
      next_lat_data = wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      count <= 32'h0000_0000;
      keep <= 1'b0;
      lat_addr <= '0;
      lat_data <= 8'h00;
    end else begin
      busy <= next_busy;
      count <= next_count;
      keep <= next_keep;
      lat_addr <= next_lat_addr;
      lat_data <= next_lat_data;
    end
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (done && keep) begin
      mem[lat_addr] <= lat_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule : dea_nv_array

// >>> verif/dea_cpu_model.sv
// CPU-side register access model
`timescale 1ns/1ps
module dea_cpu_model (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output dea_pkg::dea_bus_req_type bus_req
);
  import dea_pkg::*;
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  initial begin
    bus_req = '0;
  end
  // One access at a time, nothing slipped between steps
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    #1;
    bus_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: addr, wdata: data};
    @(posedge clk_sys);
    #1;
    bus_req.wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    #1;
    bus_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk_sys);
    #1;
    bus_req.rd_en = 1'b0;
    @(posedge clk_sys);
    #1;
    data = reg_rdata;
  endtask : rd
endmodule : dea_cpu_model

// >>> verif/data_eeprom_access_ctrl_tb.sv
// Testbench for the data EEPROM access controller
`timescale 1ns/1ps
`include "dea_defs.svh"
module data_eeprom_access_ctrl_tb;
  import dea_pkg::*;
  localparam int WR_CYC = 5;
  localparam int PU_CYC = 40;
  logic clk_sys;
  logic rst_n;
  logic external_reset_pin;
  logic watchdog_timeout;
  dea_bus_req_type bus_req;
  logic [7:0] reg_rdata;
  logic write_complete_flag;
  logic write_busy;
  logic powerup_delay_timer;
  int failures = 0;
  int tests_run = 0;
  int cyc;
  // ----------------------------------------
  // Design and CPU model
  // ----------------------------------------
  dea_access_ctrl #(
    .ADDR_BITS(6),
    .WRITE_CYCLES(WR_CYC),
    .POWERUP_CYCLES(PU_CYC)
  ) dea_access_ctrl_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .reg_rdata(reg_rdata),
    .external_reset_pin(external_reset_pin),
    .watchdog_timeout(watchdog_timeout),
    .write_complete_flag(write_complete_flag),
    .write_busy(write_busy),
    .powerup_delay_timer(powerup_delay_timer)
  );
  dea_cpu_model dea_cpu_model_inst (
    .clk_sys(clk_sys),
    .reg_rdata(reg_rdata),
    .bus_req(bus_req)
  );
  always #10 clk_sys = ~clk_sys;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic summarize();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : chk1
  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    dea_cpu_model_inst.rd(addr, v);
    chk8(v, exp, "register read");
  endtask : rdc
  task automatic wait_busy(input logic lvl, output int n);
    n = 0;
    while (write_busy !== lvl) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 50) begin
        failures++;
        $display("mismatch at %0t: busy wait timed out", $time);
        summarize();
      end
    end
  endtask : wait_busy
  // Gate write, two key bytes, optional stray read, trigger
  task automatic try_write(input logic [7:0] gate, input logic [7:0] k1,
                           input logic [7:0] k2, input logic mid, input logic exp);
    logic [7:0] v;
    dea_cpu_model_inst.wr(`DEA_OFS_CTRL, gate);
    dea_cpu_model_inst.wr(`DEA_OFS_KEY, k1);
    if (mid) begin
      dea_cpu_model_inst.rd(`DEA_OFS_DATA, v);
    end
    dea_cpu_model_inst.wr(`DEA_OFS_KEY, k2);
    dea_cpu_model_inst.wr(`DEA_OFS_CTRL, gate | 8'h02);
    @(posedge clk_sys);
    #1;
    chk1(write_busy, exp, "write start");
  endtask : try_write
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    external_reset_pin = 1'b0;
    watchdog_timeout = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk1(powerup_delay_timer, 1'b1, "power-up delay");
    rdc(`DEA_OFS_CTRL, 8'h00);
    rdc(`DEA_OFS_KEY, 8'h00);
    rdc(8'h0a, 8'h00);
    try_write(8'h04, 8'h55, 8'haa, 1'b0, 1'b0);
    repeat (PU_CYC) @(posedge clk_sys);
    #1;
    chk1(powerup_delay_timer, 1'b0, "power-up delay over");
    try_write(8'h04, 8'haa, 8'h55, 1'b0, 1'b0);
    try_write(8'h04, 8'h55, 8'h55, 1'b0, 1'b0);
    try_write(8'h04, 8'h55, 8'haa, 1'b1, 1'b0);
    try_write(8'h00, 8'h55, 8'haa, 1'b0, 1'b0);
    dea_cpu_model_inst.wr(`DEA_OFS_ADDR, 8'h05);
    dea_cpu_model_inst.wr(`DEA_OFS_DATA, 8'ha5);
    try_write(8'h04, 8'h55, 8'haa, 1'b0, 1'b1);
    dea_cpu_model_inst.wr(`DEA_OFS_CTRL, 8'h04);
    chk1(write_busy, 1'b1, "trigger not clearable");
    rdc(`DEA_OFS_CTRL, 8'h06);
    wait_busy(1'b0, cyc);
    chk1(write_complete_flag, 1'b1, "complete flag");
    rdc(`DEA_OFS_CTRL, 8'h14);
    repeat (10) @(posedge clk_sys);
    #1;
    chk1(write_complete_flag, 1'b1, "flag sticky");
    dea_cpu_model_inst.wr(`DEA_OFS_CTRL, 8'h00);
    chk1(write_complete_flag, 1'b0, "flag cleared");
    dea_cpu_model_inst.wr(`DEA_OFS_DATA, 8'h3c);
    rdc(`DEA_OFS_DATA, 8'h3c);
    dea_cpu_model_inst.wr(`DEA_OFS_CTRL, 8'h01);
    rdc(`DEA_OFS_DATA, 8'ha5);
    rdc(`DEA_OFS_CTRL, 8'h00);
    dea_cpu_model_inst.wr(`DEA_OFS_ADDR, 8'h06);
    dea_cpu_model_inst.wr(`DEA_OFS_DATA, 8'h5a);
    try_write(8'h04, 8'h55, 8'haa, 1'b0, 1'b1);
    dea_cpu_model_inst.wr(`DEA_OFS_CTRL, 8'h00);
    wait_busy(1'b0, cyc);
    chk8(8'(cyc), 8'(WR_CYC - 3), "write time");
    chk1(write_complete_flag, 1'b1, "gate clear mid-write");
    dea_cpu_model_inst.wr(`DEA_OFS_CTRL, 8'h01);
    rdc(`DEA_OFS_DATA, 8'h5a);
    dea_cpu_model_inst.wr(`DEA_OFS_ADDR, 8'h45);
    dea_cpu_model_inst.wr(`DEA_OFS_CTRL, 8'h01);
    rdc(`DEA_OFS_DATA, 8'h00);
    for (int i = 0; i < 2; i++) begin
      dea_cpu_model_inst.wr(`DEA_OFS_ADDR, 8'h07);
      dea_cpu_model_inst.wr(`DEA_OFS_DATA, 8'h77);
      try_write(8'h04, 8'h55, 8'haa, 1'b0, 1'b1);
      external_reset_pin = (i == 0);
      watchdog_timeout = (i == 1);
      repeat (2) @(posedge clk_sys);
      #1;
      external_reset_pin = 1'b0;
      watchdog_timeout = 1'b0;
      chk1(write_busy, 1'b0, "write killed");
      rdc(`DEA_OFS_CTRL, 8'h08);
      rdc(`DEA_OFS_ADDR, 8'h07);
      rdc(`DEA_OFS_DATA, 8'h77);
    end
    dea_cpu_model_inst.wr(`DEA_OFS_CTRL, 8'h04);
    rdc(`DEA_OFS_CTRL, 8'h04);
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk1(powerup_delay_timer, 1'b1, "power-up delay again");
    rdc(`DEA_OFS_CTRL, 8'h00);
    try_write(8'h04, 8'h55, 8'haa, 1'b0, 1'b0);
    summarize();
  end
endmodule : data_eeprom_access_ctrl_tb
